// *** spdwc_defines.vh ***
// Constants for the deep stop power-down and wake controller
`ifndef SPDWC_DEFINES_VH
`define SPDWC_DEFINES_VH
`define SPDWC_ADDR_W 8
`define SPDWC_DATA_W 8
`define SPDWC_OFS_CTRL 8'h00
`define SPDWC_OFS_PMSC2 8'h01
`define SPDWC_OFS_STATUS 8'h02
`define SPDWC_OFS_STOPCFG 8'h03
`define SPDWC_CTRL_STOPEN 0
`define SPDWC_CTRL_LOWVOLT_DETECT_ENABLE 1
`define SPDWC_CTRL_LOWVOLT_STOP_ENABLE 2
`define SPDWC_CTRL_PPDSEL 3
`define SPDWC_CTRL_RTCEN 4
`define SPDWC_CTRL_RESET 8'h00
`define SPDWC_PMSC2_FLAG 3
`define SPDWC_PMSC2_ACK 2
`define SPDWC_PMSC2_PPDSEL 0
`define SPDWC_CFG_IRCLK 0
`define SPDWC_CFG_IREFST 1
`define SPDWC_CFG_ERCLK 2
`define SPDWC_CFG_EREFST 3
`define SPDWC_CFG_RANGE 4
`define SPDWC_CFG_ADCASY 5
`define SPDWC_CFG_RESET 8'h00
`define SPDWC_RESET_VEC 16'hFFFE
`define SPDWC_POR_TIME_NS 1000
// Wake reset length in clock cycles: 1000 ns at 20 ns per cycle
`define SPDWC_POR_CYC 16'd50
`endif

// *** spdwc_top.v ***
// Deep stop power-down entry, wake, recovery flag and pin latch control
`timescale 1ns/1ps
`include "spdwc_defines.vh"

// Behaviour
// - Stop instruction picks deep stop when enabled, no debug, not both low-volt bits set, select set.
// - Stop instruction with stop disabled raises an illegal-opcode reset pulse.
// - Deep stop removes core power and keeps RAM in standby.
// - Entering deep stop latches all pin control signals.
// - Asserted external reset wakes the device from deep stop.
// - Early revisions also wake from deep stop on the legacy wake pin.
// - Legacy wake pin is always active low, whatever its configuration before stopping.
// - Enabled real-time counter event wakes from deep stop.
// - Wake resets control, stop-config and select registers as after power-on.
// - Wake enables low-volt reset at low trip, holds reset while supply low.
// - After wake the processor fetches from the reset vector at top of memory.
// - Wake sets the recovery flag in the second power status register.
// - Flag and pin latches stay until software writes one to acknowledge.
// - On acknowledge pins take their current port register values.
// - Unrestored peripheral pins pass to port control on latch release.
// - Every stop state stops peripheral clocks, even with debug enabled.
// - Light stop keeps converter on only with async clock and detector.
// - Light stop keeps clock generator on only with both internal enables.
// - Light stop keeps crystal on with both enables; high range needs detector.
// - Light stop keeps regulator on only with detector or debug enabled.
// - Real-time counter runs in any stop only when enabled.
// - Debug enable turns a deep stop request into light stop.
// - Low-volt stop enable with low-volt detect enable turns a deep stop request into light stop.
module spdwc_top (
	input wire core_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire stop_instr,
	input wire debug_mode_enable,
	input wire early_revision,
	input wire ext_reset_n,
	input wire legacy_wake_pin,
	input wire rtc_event,
	input wire supply_below_trip,
	output reg illegal_opcode_reset,
	output reg core_power_on,
	output reg ram_standby,
	output reg pin_latch_hold,
	output reg periph_clk_en,
	output reg light_stop,
	output reg deep_stop,
	output reg adc_run,
	output reg clockgen_run,
	output reg crystal_run,
	output reg regulator_run,
	output reg rtc_run,
	output reg por_reset,
	output reg [15:0] fetch_vector,
	output reg lowvolt_reset_enable,
	output reg lowvolt_low_trip
);

	localparam ST_RUN = 4'b0001;
	localparam ST_LIGHT = 4'b0010;
	localparam ST_DEEP = 4'b0100;
	localparam ST_WAKE = 4'b1000;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [7:0] ctrl_reg;
	reg [7:0] cfg_reg;
	reg ppd_sel_reg;
	reg flag_reg;
	reg [15:0] por_cnt_reg;
	reg rst_s1_reg;
	reg rst_s2_reg;
	reg wk_s1_reg;
	reg wk_s2_reg;
	reg lv_s1_reg;
	reg lv_s2_reg;

	function is_addr;
		input [7:0] a;
		input [7:0] ofs;
		begin
			is_addr = (a == ofs);
		end
	endfunction

	wire stop_en = ctrl_reg[`SPDWC_CTRL_STOPEN];
	wire lowvolt_detect_enable = ctrl_reg[`SPDWC_CTRL_LOWVOLT_DETECT_ENABLE];
	wire lowvolt_stop_enable = ctrl_reg[`SPDWC_CTRL_LOWVOLT_STOP_ENABLE];
	wire rtc_en = ctrl_reg[`SPDWC_CTRL_RTCEN];
	wire wr_ctrl = reg_wr && is_addr(reg_addr, `SPDWC_OFS_CTRL);
	wire wr_pmsc2 = reg_wr && is_addr(reg_addr, `SPDWC_OFS_PMSC2);
	wire wr_cfg = reg_wr && is_addr(reg_addr, `SPDWC_OFS_STOPCFG);
	// Acknowledge only on a written one
	wire ack_wr = wr_pmsc2 && reg_wdata[`SPDWC_PMSC2_ACK];
	// Deep stop only with debug off and not both low-volt bits set
	wire pick_deep = ppd_sel_reg && !debug_mode_enable
		&& !(lowvolt_detect_enable && lowvolt_stop_enable);
	wire wake_src = !rst_s2_reg
		|| (early_revision && !wk_s2_reg)
		|| (rtc_en && rtc_event);
	wire por_done = (por_cnt_reg == 16'h0000) && !lv_s2_reg;
	// Light stop keep-alive fields
	wire int_refclk_enable = cfg_reg[`SPDWC_CFG_IRCLK];
	wire int_ref_stop_enable = cfg_reg[`SPDWC_CFG_IREFST];
	wire ext_refclk_enable = cfg_reg[`SPDWC_CFG_ERCLK];
	wire ext_ref_stop_enable = cfg_reg[`SPDWC_CFG_EREFST];
	wire cfg_high_range = cfg_reg[`SPDWC_CFG_RANGE];
	wire adc_async_clk = cfg_reg[`SPDWC_CFG_ADCASY];

	always @(posedge core_clk) begin
		if (rst) begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= 1'b1;
			wk_s1_reg <= 1'b1;
			wk_s2_reg <= 1'b1;
			lv_s1_reg <= 1'b0;
			lv_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= ext_reset_n;
			rst_s2_reg <= rst_s1_reg;
			wk_s1_reg <= legacy_wake_pin;
			wk_s2_reg <= wk_s1_reg;
			lv_s1_reg <= supply_below_trip;
			lv_s2_reg <= lv_s1_reg;
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (stop_instr && stop_en) begin
					state_next = pick_deep ? ST_DEEP : ST_LIGHT;
				end
			end
			ST_LIGHT: begin
				if (wake_src) begin
					state_next = ST_RUN;
				end
			end
			ST_DEEP: begin
				if (wake_src) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// Held in reset until count ends and supply is above trip
				if (por_done) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	wire enter_wake = (state_reg == ST_DEEP) && (state_next == ST_WAKE);
	wire ack_ok = ack_wr && (state_reg == ST_RUN);

	always @(posedge core_clk) begin
		if (rst) begin
			state_reg <= ST_RUN;
			ctrl_reg <= `SPDWC_CTRL_RESET;
			cfg_reg <= `SPDWC_CFG_RESET;
			ppd_sel_reg <= 1'b0;
			por_cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			if (enter_wake) begin
				// Power-on style reset of module registers
				ctrl_reg <= `SPDWC_CTRL_RESET;
				cfg_reg <= `SPDWC_CFG_RESET;
				ppd_sel_reg <= 1'b0;
				por_cnt_reg <= `SPDWC_POR_CYC;
			end else begin
				if (state_reg == ST_WAKE && por_cnt_reg != 16'h0000) begin
					por_cnt_reg <= por_cnt_reg - 16'h0001;
				end
				if (wr_ctrl) begin
					ctrl_reg <= reg_wdata;
				end
				if (wr_cfg) begin
					cfg_reg <= reg_wdata;
				end
				if (wr_pmsc2) begin
					ppd_sel_reg <= reg_wdata[`SPDWC_PMSC2_PPDSEL];
				end
			end
		end
	end

	// Set wins over acknowledge in the same cycle
	always @(posedge core_clk) begin
		if (rst) begin
			flag_reg <= 1'b0;
		end else if (enter_wake) begin
			flag_reg <= 1'b1;
		end else if (ack_ok) begin
			flag_reg <= 1'b0;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`SPDWC_OFS_CTRL: reg_rdata <= ctrl_reg;
				// Acknowledge bit always reads zero
				`SPDWC_OFS_PMSC2: reg_rdata <= {4'h0, flag_reg, 1'b0,
					1'b0, ppd_sel_reg};
				`SPDWC_OFS_STATUS: reg_rdata <= {4'h0, state_reg};
				`SPDWC_OFS_STOPCFG: reg_rdata <= cfg_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	wire nxt_light = (state_next == ST_LIGHT);
	wire nxt_deep = (state_next == ST_DEEP);
	wire nxt_stop = nxt_light || nxt_deep;
	wire nxt_wake = (state_next == ST_WAKE);
	// Latch holds through deep stop and recovery until acknowledged
	wire nxt_latch = nxt_deep || nxt_wake
		|| (flag_reg && !(ack_wr && state_reg == ST_RUN));

	// Stop with stop disabled gives a one-cycle reset request
	always @(posedge core_clk) begin
		if (rst) begin
			illegal_opcode_reset <= 1'b0;
		end else begin
			illegal_opcode_reset <= (state_reg == ST_RUN) && stop_instr
				&& !stop_en;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			core_power_on <= 1'b1;
		end else begin
			core_power_on <= !nxt_deep;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			ram_standby <= 1'b0;
		end else begin
			ram_standby <= nxt_stop;
		end
	end

	// On release pins follow port registers and peripherals
	always @(posedge core_clk) begin
		if (rst) begin
			pin_latch_hold <= 1'b0;
		end else begin
			pin_latch_hold <= nxt_latch;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			periph_clk_en <= 1'b1;
		end else begin
			periph_clk_en <= !nxt_stop;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			light_stop <= 1'b0;
		end else begin
			light_stop <= nxt_light;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			deep_stop <= 1'b0;
		end else begin
			deep_stop <= nxt_deep;
		end
	end

	// Converter, clock generator, crystal and regulator keep-alive
	always @(posedge core_clk) begin
		if (rst) begin
			adc_run <= 1'b0;
		end else begin
			adc_run <= !nxt_stop || (nxt_light
				&& adc_async_clk && lowvolt_detect_enable);
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			clockgen_run <= 1'b0;
		end else begin
			clockgen_run <= !nxt_stop || (nxt_light
				&& int_refclk_enable
				&& int_ref_stop_enable);
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			crystal_run <= 1'b0;
		end else begin
			crystal_run <= !nxt_stop || (nxt_light
				&& ext_refclk_enable
				&& ext_ref_stop_enable
				&& (!cfg_high_range || lowvolt_detect_enable));
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			regulator_run <= 1'b1;
		end else begin
			regulator_run <= !nxt_stop || (nxt_light
				&& (lowvolt_detect_enable || debug_mode_enable));
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			rtc_run <= 1'b0;
		end else begin
			rtc_run <= rtc_en;
		end
	end

	// Wake reset stands for the whole recovery count
	always @(posedge core_clk) begin
		if (rst) begin
			por_reset <= 1'b0;
		end else begin
			por_reset <= nxt_wake;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			fetch_vector <= `SPDWC_RESET_VEC;
		end else begin
			fetch_vector <= `SPDWC_RESET_VEC;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			lowvolt_reset_enable <= 1'b1;
		end else begin
			lowvolt_reset_enable <= lowvolt_reset_enable
				|| nxt_wake;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			lowvolt_low_trip <= 1'b1;
		end else begin
			lowvolt_low_trip <= lowvolt_low_trip || nxt_wake;
		end
	end

endmodule

// *** spdwc_wake_src.sv ***
// Wake source model: reset pin, legacy wake pin and counter event
`timescale 1ns/1ps
module spdwc_wake_src (
	input wire core_clk,
	input wire fire,
	input wire [1:0] kind,
	output wire ext_reset_n,
	output wire legacy_wake_pin,
	output wire rtc_event
);
	logic [2:0] cnt_reg = 3'h0;
	wire act = cnt_reg != 3'h0;
	// A wake request lasts four cycles; idle levels are inactive
	always @(posedge core_clk)
		cnt_reg <= fire ? 3'h4 : cnt_reg - {2'h0, act};
	assign ext_reset_n = !(act && kind == 2'h0);
	assign legacy_wake_pin = !(act && kind == 2'h1);
	assign rtc_event = act && kind == 2'h2;
endmodule

// *** spdwc_chk_sva.sv ***
// Port assertions for the deep stop controller
`timescale 1ns/1ps
module spdwc_chk (
	input wire core_clk,
	input wire rst,
	input wire reg_wr,
	input wire stop_instr,
	input wire debug_mode_enable,
	input wire illegal_opcode_reset,
	input wire core_power_on,
	input wire pin_latch_hold,
	input wire periph_clk_en,
	input wire light_stop,
	input wire deep_stop,
	input wire por_reset,
	input wire lowvolt_reset_enable
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_deep_power: assert property (
		deep_stop |-> !core_power_on && !periph_clk_en) else $error("deep pwr");
	a_latch_entry: assert property (
		$rose(deep_stop) |-> pin_latch_hold) else $error("latch open");
	a_latch_keep: assert property (
		pin_latch_hold && !reg_wr |=> pin_latch_hold) else $error("latch drop");
	a_light_clk: assert property (
		light_stop |-> !periph_clk_en) else $error("light clk");
	a_debug_light: assert property (
		stop_instr && debug_mode_enable && !deep_stop |=> !deep_stop)
		else $error("debug deep");
	a_illegal_src: assert property (
		$rose(illegal_opcode_reset) |-> $past(stop_instr)) else $error("illeg");
	a_wake_por: assert property (
		$fell(deep_stop) |-> por_reset) else $error("no por");
	a_por_lowvolt: assert property (
		por_reset |-> lowvolt_reset_enable) else $error("lowvolt off");
	cover property ($rose(deep_stop));
	cover property ($rose(light_stop));
	cover property ($rose(illegal_opcode_reset));
endmodule

// *** tb_top.sv ***
// Self-checking bench for the deep stop controller
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic stop_instr = 1'b0, debug_mode_enable = 1'b0, fire = 1'b0;
	logic early_revision = 1'b0, supply_below_trip = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [1:0] kind = 2'h0;
	wire [7:0] reg_rdata;
	wire [15:0] fetch_vector;
	wire ext_reset_n, legacy_wake_pin, rtc_event, illegal_opcode_reset;
	wire core_power_on, ram_standby, pin_latch_hold, periph_clk_en, rtc_run;
	wire light_stop, deep_stop, adc_run, clockgen_run, crystal_run, por_reset;
	wire regulator_run, lowvolt_reset_enable, lowvolt_low_trip;
	int errors = 0, checks = 0;
	spdwc_wake_src u_src (
		.core_clk(core_clk),
		.fire(fire),
		.kind(kind),
		.ext_reset_n(ext_reset_n),
		.legacy_wake_pin(legacy_wake_pin),
		.rtc_event(rtc_event)
	);
	spdwc_top u_dut (
		.core_clk(core_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.stop_instr(stop_instr),
		.debug_mode_enable(debug_mode_enable),
		.early_revision(early_revision),
		.ext_reset_n(ext_reset_n),
		.legacy_wake_pin(legacy_wake_pin),
		.rtc_event(rtc_event),
		.supply_below_trip(supply_below_trip),
		.illegal_opcode_reset(illegal_opcode_reset),
		.core_power_on(core_power_on),
		.ram_standby(ram_standby),
		.pin_latch_hold(pin_latch_hold),
		.periph_clk_en(periph_clk_en),
		.light_stop(light_stop),
		.deep_stop(deep_stop),
		.adc_run(adc_run),
		.clockgen_run(clockgen_run),
		.crystal_run(crystal_run),
		.regulator_run(regulator_run),
		.rtc_run(rtc_run),
		.por_reset(por_reset),
		.fetch_vector(fetch_vector),
		.lowvolt_reset_enable(lowvolt_reset_enable),
		.lowvolt_low_trip(lowvolt_low_trip)
	);
	task cmp(string nm, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task acc(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'h0;
		if (!w) begin
			@(negedge core_clk);
			cmp("rdata", d, reg_rdata);
		end
	endtask
	// State byte: illegal, deep, light, periph clock, core power, clockgen
	// Power byte: ram, adc, crystal, regulator, rtc, por, lowvolt en, trip
	task run_stop(logic [7:0] ctrl, logic [7:0] exp, logic [7:0] pwr,
		logic [1:0] k);
		acc(1'b1, 8'h00, ctrl);
		acc(1'b1, 8'h01, 8'h01);
		@(posedge core_clk);
		stop_instr <= 1'b1;
		kind <= k;
		@(posedge core_clk);
		stop_instr <= 1'b0;
		fire <= 1'b1;
		@(negedge core_clk);
		cmp("state", exp, {2'h0, illegal_opcode_reset, deep_stop,
			light_stop, periph_clk_en, core_power_on, clockgen_run});
		cmp("power", pwr, {ram_standby, adc_run, crystal_run,
			regulator_run, rtc_run, por_reset, lowvolt_reset_enable,
			lowvolt_low_trip});
		@(posedge core_clk);
		fire <= 1'b0;
		for (int i = 0; i < 200 && (deep_stop | light_stop | por_reset); i++)
			@(posedge core_clk);
		repeat (6) @(posedge core_clk);
		if (exp[4]) begin
			acc(1'b0, 8'h01, 8'h08);
			cmp("vec_hi", 8'hFF, fetch_vector[15:8]);
			cmp("vec_lo", 8'hFE, fetch_vector[7:0]);
			acc(1'b1, 8'h01, 8'h00);
			acc(1'b0, 8'h01, 8'h08);
			cmp("latch", 8'h01, {7'h00, pin_latch_hold});
			acc(1'b1, 8'h01, 8'h04);
			acc(1'b0, 8'h01, 8'h00);
			cmp("latch", 8'h00, {7'h00, pin_latch_hold});
		end
		$display("test ctrl %h kind %0d done", ctrl, k);
		@(posedge core_clk);
	endtask
	task print_verdict(logic hung);
		errors += int'(hung);
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #10 core_clk = ~core_clk;
	initial #100000 print_verdict(1'b1);
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		acc(1'b0, 8'h01, 8'h00);
		acc(1'b0, 8'h20, 8'h00);
		acc(1'b0, 8'h02, 8'h01);
		run_stop(8'h00, 8'h27, 8'h73, 2'h3);
		run_stop(8'h01, 8'h10, 8'h83, 2'h0);
		early_revision <= 1'b1;
		run_stop(8'h01, 8'h10, 8'h83, 2'h1);
		run_stop(8'h11, 8'h10, 8'h8B, 2'h2);
		acc(1'b1, 8'h03, 8'h2F);
		run_stop(8'h07, 8'h0B, 8'hF3, 2'h0);
		acc(1'b1, 8'h03, 8'h3F);
		debug_mode_enable <= 1'b1;
		run_stop(8'h01, 8'h0B, 8'h93, 2'h0);
		print_verdict(1'b0);
	end
endmodule
bind spdwc_top spdwc_chk u_chk (
	.core_clk(core_clk),
	.rst(rst),
	.reg_wr(reg_wr),
	.stop_instr(stop_instr),
	.debug_mode_enable(debug_mode_enable),
	.illegal_opcode_reset(illegal_opcode_reset),
	.core_power_on(core_power_on),
	.pin_latch_hold(pin_latch_hold),
	.periph_clk_en(periph_clk_en),
	.light_stop(light_stop),
	.deep_stop(deep_stop),
	.por_reset(por_reset),
	.lowvolt_reset_enable(lowvolt_reset_enable)
);
